// [hw/tcio_pkg.sv]
// package: register map, field layout and mode decode for the channel-3 register-A i/o control
package tcio_pkg;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 3;
   localparam int FLD_W = 4;
   // register offsets (word addresses on the plain register port)
   localparam logic [ADDR_W-1:0] ADDR_IOCTL_HI = 3'h0;
   localparam logic [ADDR_W-1:0] ADDR_GENA = 3'h1;
   localparam logic [ADDR_W-1:0] ADDR_CNT = 3'h2;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 3'h3;
   localparam logic [ADDR_W-1:0] ADDR_STAT = 3'h4;
   localparam logic [ADDR_W-1:0] ADDR_CH2_IOCTL = 3'h5;
   localparam logic [ADDR_W-1:0] ADDR_CH2_GENA = 3'h6;
   // field positions
   localparam int IO_FLD_LSB = 0;
   localparam int IOB_FLD_LSB = 4;
   localparam int IO_CAP_BIT = 3;
   localparam int IO_INIT_BIT = 2;
   localparam int IO_SRC_BIT = 2;
   localparam int IO_BOTH_BIT = 1;
   localparam int IO_FALL_BIT = 0;
   localparam int CTRL_RUN_BIT = 0;
   localparam int STAT_CMP_BIT = 0;
   localparam int STAT_CAP3_BIT = 1;
   localparam int STAT_CAP2_BIT = 2;
   localparam int STAT_W = 3;
   // reset values
   localparam logic [7:0] IOCTL_RST = 8'h00;
   localparam logic [FLD_W-1:0] CH2_IOCTL_RST = 4'h0;
   localparam logic [DATA_W-1:0] GEN_RST = 16'h0000;
   // compare-match actions, low two bits of the field
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_LOW = 2'h1;
   localparam logic [1:0] ACT_HIGH = 2'h2;
   localparam logic [1:0] ACT_TOG = 2'h3;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } tcio_bus_req_t;

   typedef struct packed {
      logic outEn;
      logic initLvl;
      logic [1:0] act;
      logic capPin;
      logic capRise;
      logic capFall;
      logic capCh4;
   } tcio_mode_t;

   // decode of the four-bit register-A i/o control field
   function automatic tcio_mode_t tcio_decode(input logic [FLD_W-1:0] f);
      tcio_mode_t m;
      m = '0;
      if (!f[IO_CAP_BIT]) begin
         m.act = f[1:0];
         m.outEn = (f[1:0] != ACT_NONE);
         m.initLvl = f[IO_INIT_BIT];
      end else if (f[IO_SRC_BIT]) begin
         m.capCh4 = 1'b1;
      end else begin
         m.capPin = 1'b1;
         m.capRise = f[IO_BOTH_BIT] | ~f[IO_FALL_BIT];
         m.capFall = f[IO_BOTH_BIT] | f[IO_FALL_BIT];
      end
      return m;
   endfunction : tcio_decode
endpackage : tcio_pkg

// [hw/tcio_edge_det.sv]
// module: pin edge detector with rise/fall selection
module tcio_edge_det (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic pinIn,
   input wire logic selRise,
   input wire logic selFall,
   output logic edgeEvt
);
   logic prev_r;
   logic primed_r;

   // previous pin level, valid once primed after reset
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         prev_r <= 1'b0;
         primed_r <= 1'b0;
      end else begin
         prev_r <= pinIn;
         primed_r <= 1'b1;
      end
   end

   // no spurious edge on the first cycle after reset
   assign edgeEvt = primed_r & ((selRise & pinIn & ~prev_r) | (selFall & ~pinIn & prev_r));
endmodule : tcio_edge_det

// [hw/tcio_gen_reg.sv]
// module: general register with software write and capture load
module tcio_gen_reg #(
   parameter int W = 16
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic wrEn,
   input wire logic [W-1:0] wrData,
   input wire logic capEn,
   input wire logic [W-1:0] capData,
   output logic [W-1:0] value
);
   logic [W-1:0] val_r;

   // software write takes priority over a capture in the same cycle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         val_r <= '0;
      end else if (wrEn) begin
         val_r <= wrData;
      end else if (capEn) begin
         val_r <= capData;
      end
   end

   assign value = val_r;
endmodule : tcio_gen_reg

// [hw/tcio_ch3_io_ctrl.sv]
// module: channel-3 register-A compare output and capture control
import tcio_pkg::*;

module tcio_ch3_io_ctrl import tcio_pkg::*; #(
   parameter int CNT_W = DATA_W
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire tcio_bus_req_t busReq,
   output logic [DATA_W-1:0] regRdData,
   input wire logic channel3_pin_a_in,
   output logic channel3_pin_a_out,
   output logic channel3_pin_a_oe,
   input wire logic channel2_pin_a_in,
   input wire logic channel4_count_evt
);
   generate
      if (CNT_W != DATA_W) begin : gBadW
         $error("CNT_W must equal DATA_W");
      end
   endgenerate

   logic [7:0] channel3_io_control_high_r;
   logic [FLD_W-1:0] ch2IoCtl_r;
   logic [CNT_W-1:0] cnt_r;
   logic run_r;
   logic [STAT_W-1:0] stat_r;
   logic pinOut_r;
   logic pinOe_r;
   logic [DATA_W-1:0] rdData_r;
   logic [DATA_W-1:0] genA;
   logic [DATA_W-1:0] ch2GenA;
   logic [FLD_W-1:0] fld;
   logic [FLD_W-1:0] ch2Fld;
   tcio_mode_t mode3;
   tcio_mode_t mode2;
   tcio_mode_t modeNew;
   logic wrIo;
   logic wrGenA;
   logic wrCh2GenA;
   logic cmpMatch;
   logic pinEdge3;
   logic pinEdge2;
   logic cap3;
   logic cap2;

   // field decode and write strobes
   assign fld = channel3_io_control_high_r[IO_FLD_LSB +: FLD_W];
   assign mode3 = tcio_decode(fld);
   assign mode2 = tcio_decode(ch2Fld);
   assign modeNew = tcio_decode(busReq.data[IO_FLD_LSB +: FLD_W]);
   assign wrIo = busReq.wr && busReq.addr == ADDR_IOCTL_HI;
   assign wrGenA = busReq.wr && busReq.addr == ADDR_GENA;
   assign wrCh2GenA = busReq.wr && busReq.addr == ADDR_CH2_GENA;

   // channel-2 capture ignores bit 2, its own pin is the only source
   always_comb begin
      ch2Fld = ch2IoCtl_r;
      ch2Fld[IO_SRC_BIT] = ch2IoCtl_r[IO_SRC_BIT] & ~ch2IoCtl_r[IO_CAP_BIT];
   end

   // compare match only while the register is in compare mode
   assign cmpMatch = run_r && !fld[IO_CAP_BIT] && cnt_r == genA;

   // channel-3 pin edge detection, pin is the only source in 10xx
   tcio_edge_det uEdge3 (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .pinIn(channel3_pin_a_in),
      .selRise(mode3.capRise),
      .selFall(mode3.capFall),
      .edgeEvt(pinEdge3)
   );
   assign cap3 = (mode3.capPin && pinEdge3) || (mode3.capCh4 && channel4_count_evt);

   // channel-2 pin edge detection
   tcio_edge_det uEdge2 (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .pinIn(channel2_pin_a_in),
      .selRise(mode2.capRise),
      .selFall(mode2.capFall),
      .edgeEvt(pinEdge2)
   );
   assign cap2 = mode2.capPin && pinEdge2;

   // general registers with capture of the counter
   tcio_gen_reg #(.W(DATA_W)) uGenA (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .wrEn(wrGenA),
      .wrData(busReq.data),
      .capEn(cap3),
      .capData(cnt_r),
      .value(genA)
   );

   tcio_gen_reg #(.W(DATA_W)) uCh2GenA (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .wrEn(wrCh2GenA),
      .wrData(busReq.data),
      .capEn(cap2),
      .capData(cnt_r),
      .value(ch2GenA)
   );

   // control registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         channel3_io_control_high_r <= IOCTL_RST;
         ch2IoCtl_r <= CH2_IOCTL_RST;
         run_r <= 1'b0;
      end else if (busReq.wr) begin
         case (busReq.addr)
            ADDR_IOCTL_HI: channel3_io_control_high_r <= busReq.data[7:0];
            ADDR_CH2_IOCTL: ch2IoCtl_r <= busReq.data[FLD_W-1:0];
            ADDR_CTRL: run_r <= busReq.data[CTRL_RUN_BIT];
            default: ;
         endcase
      end
   end

   // free-running counter, software write wins
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= GEN_RST;
      end else if (busReq.wr && busReq.addr == ADDR_CNT) begin
         cnt_r <= busReq.data;
      end else if (run_r) begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   // sticky event flags, write one to clear, a new event wins
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         stat_r <= '0;
      end else begin
         for (int i = 0; i < STAT_W; i++) begin
            if (busReq.wr && busReq.addr == ADDR_STAT && busReq.data[i]) begin
               stat_r[i] <= 1'b0;
            end
         end
         if (cmpMatch) begin
            stat_r[STAT_CMP_BIT] <= 1'b1;
         end
         if (cap3) begin
            stat_r[STAT_CAP3_BIT] <= 1'b1;
         end
         if (cap2) begin
            stat_r[STAT_CAP2_BIT] <= 1'b1;
         end
      end
   end

   // pin drive: initial level on write, then match actions
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pinOut_r <= 1'b0;
         pinOe_r <= 1'b0;
      end else if (wrIo) begin
         pinOe_r <= modeNew.outEn;
         pinOut_r <= modeNew.outEn & modeNew.initLvl;
      end else if (cmpMatch) begin
         case (mode3.act)
            ACT_LOW: pinOut_r <= 1'b0;
            ACT_HIGH: pinOut_r <= 1'b1;
            ACT_TOG: pinOut_r <= ~pinOut_r;
            default: ;
         endcase
      end
   end

   // register read, data stand one cycle after the strobe
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdData_r <= '0;
      end else if (busReq.rd) begin
         case (busReq.addr)
            ADDR_IOCTL_HI: rdData_r <= {8'h00, channel3_io_control_high_r};
            ADDR_GENA: rdData_r <= genA;
            ADDR_CNT: rdData_r <= cnt_r;
            ADDR_CTRL: rdData_r <= {{(DATA_W-1){1'b0}}, run_r};
            ADDR_STAT: rdData_r <= {{(DATA_W-STAT_W){1'b0}}, stat_r};
            ADDR_CH2_IOCTL: rdData_r <= {{(DATA_W-FLD_W){1'b0}}, ch2IoCtl_r};
            ADDR_CH2_GENA: rdData_r <= ch2GenA;
            default: rdData_r <= '0;
         endcase
      end else begin
         rdData_r <= '0;
      end
   end

   assign regRdData = rdData_r;
   assign channel3_pin_a_out = pinOut_r;
   assign channel3_pin_a_oe = pinOe_r;

   // checks
   sequence sWrIo;
      busReq.wr && busReq.addr == ADDR_IOCTL_HI;
   endsequence

   sequence sMatchQuiet(logic [1:0] a);
      cmpMatch && fld[1:0] == a && !wrIo;
   endsequence

   sequence sNoGenWr;
      !wrGenA;
   endsequence

   chk_out_disable: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (fld[1:0] == ACT_NONE || fld[IO_CAP_BIT]) |-> !pinOe_r)
      else $error("pin driven while output disabled");

   chk_init_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
      sWrIo ##1 (fld[3:2] == 2'h0 && fld[1:0] != ACT_NONE) |-> pinOe_r && !pinOut_r)
      else $error("initial low level missing");

   chk_init_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
      sWrIo ##1 (fld[3:2] == 2'h1 && fld[1:0] != ACT_NONE) |-> pinOe_r && pinOut_r)
      else $error("initial high level missing");

   chk_match_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
      sMatchQuiet(ACT_LOW) |=> !pinOut_r)
      else $error("pin not low after match");

   chk_match_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
      sMatchQuiet(ACT_HIGH) |=> pinOut_r)
      else $error("pin not high after match");

   chk_match_toggle: assert property (@(posedge clk_sys) disable iff (!rst_n)
      sMatchQuiet(ACT_TOG) |=> pinOut_r != $past(pinOut_r))
      else $error("pin not toggled after match");

   chk_cap_rise: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (fld == 4'h8 && $past(rst_n) && $rose(channel3_pin_a_in)) ##0 sNoGenWr |=> genA == $past(cnt_r))
      else $error("rising edge not captured");

   chk_cap_fall: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (fld == 4'h9 && $past(rst_n) && $fell(channel3_pin_a_in)) ##0 sNoGenWr |=> genA == $past(cnt_r))
      else $error("falling edge not captured");

   chk_cap_both: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (fld[3:1] == 3'h5 && $past(rst_n) && $changed(channel3_pin_a_in)) ##0 sNoGenWr
      |=> genA == $past(cnt_r))
      else $error("pin edge not captured in both-edge mode");

   chk_cap_ch4: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (fld[3:2] == 2'h3 && channel4_count_evt) ##0 sNoGenWr |=> genA == $past(cnt_r))
      else $error("channel-4 count not captured");

   chk_ch2_cap: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (ch2IoCtl_r[IO_CAP_BIT] && $past(rst_n) && !wrCh2GenA
      && ((ch2IoCtl_r[1:0] == 2'h1 && $fell(channel2_pin_a_in))
      || (ch2IoCtl_r[IO_BOTH_BIT] && $changed(channel2_pin_a_in))))
      |=> ch2GenA == $past(cnt_r))
      else $error("channel-2 edge not captured");

   chk_pin_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (fld[3:2] == 2'h2 && channel4_count_evt && !pinEdge3 && !wrGenA) |=> $stable(genA))
      else $error("capture from other source in pin mode");

   chk_ch2_rise: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (ch2IoCtl_r[IO_CAP_BIT] && ch2IoCtl_r[1:0] == 2'h0 && $past(rst_n) && !wrCh2GenA
      && $rose(channel2_pin_a_in)) |=> ch2GenA == $past(cnt_r))
      else $error("channel-2 rising edge not captured");

   chk_ch4_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (fld[3:2] == 2'h3 && !channel4_count_evt && !wrGenA) |=> $stable(genA))
      else $error("capture without channel-4 count");

   chk_rise_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (fld == 4'h8 && !$rose(channel3_pin_a_in) && !wrGenA) |=> $stable(genA))
      else $error("capture without rising edge");

   chk_fall_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (fld == 4'h9 && !$fell(channel3_pin_a_in) && !wrGenA) |=> $stable(genA))
      else $error("capture without falling edge");

   chk_pin_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!cmpMatch && !wrIo) |=> $stable(pinOut_r) && $stable(pinOe_r))
      else $error("pin changed without write or match");

   chk_rd_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !busReq.rd |=> regRdData == '0)
      else $error("read data outside the read cycle");

   chk_cmp_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
      cmpMatch |=> stat_r[STAT_CMP_BIT])
      else $error("compare flag not set");

   chk_cap_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
      cap3 |=> stat_r[STAT_CAP3_BIT])
      else $error("capture flag not set");
endmodule : tcio_ch3_io_ctrl

// [tb/tcio_pin_model.sv]
// board side of channel-3 pin a: resolves the wire from both drivers
module tcio_pin_model (
   input wire logic driveOut,
   input wire logic driveOe,
   input wire logic boardLvl,
   output logic pinLvl
);
   timeunit 1ns;
   timeprecision 1ns;
   // the block wins while it drives, otherwise the board level shows
   assign pinLvl = driveOe ? driveOut : boardLvl;
endmodule : tcio_pin_model

// [tb/tcio_ch3_io_ctrl_bench.sv]
// testbench: register access, compare output and capture of channel-3 register a
module tcio_ch3_io_ctrl_bench;
   import tcio_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   tcio_bus_req_t busReq = '0;
   logic [DATA_W-1:0] regRdData;
   logic pinLvl, pinOut, pinOe;
   logic boardLvl = 1'b0;
   logic ch2Pin = 1'b0;
   logic ch4Evt = 1'b0;
   int fail_count = 0;
   int check_count = 0;
   logic [DATA_W-1:0] rdVal;
   logic [1:0] act;

   tcio_ch3_io_ctrl #(.CNT_W(DATA_W)) tcio_ch3_io_ctrl_i (.clk_sys(clk_sys), .rst_n(rst_n), .busReq(busReq),
      .regRdData(regRdData), .channel3_pin_a_in(pinLvl), .channel3_pin_a_out(pinOut),
      .channel3_pin_a_oe(pinOe), .channel2_pin_a_in(ch2Pin), .channel4_count_evt(ch4Evt));
   tcio_pin_model tcio_pin_model_i (.driveOut(pinOut), .driveOe(pinOe), .boardLvl(boardLvl), .pinLvl(pinLvl));

   // 10 MHz clock
   always #50 clk_sys = ~clk_sys;

   task check_val(input string name, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask : check_val

   task bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk_sys);
      busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
      @(posedge clk_sys);
      busReq <= '0;
   endtask : bus_wr

   // read data stand only in the cycle after the strobe
   task bus_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge clk_sys);
      busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 16'h0000};
      @(posedge clk_sys);
      busReq <= '0;
      #1;
      d = regRdData;
   endtask : bus_rd

   task chk_pin(input logic expOe, input logic expOut);
      #1;
      check_val("pin oe", {15'h0000, expOe}, {15'h0000, pinOe});
      check_val("pin out", {15'h0000, expOut}, {15'h0000, pinOut});
   endtask : chk_pin

   // one capture trigger with the counter frozen at cnt; genA or ch2GenA cleared first
   task cap_step(input logic ch2, input logic useCh4, input logic lvl, input logic [DATA_W-1:0] cnt,
                 input logic hit);
      logic [ADDR_W-1:0] ga;
      logic [DATA_W-1:0] v;
      ga = ch2 ? ADDR_CH2_GENA : ADDR_GENA;
      bus_wr(ADDR_CNT, cnt);
      bus_wr(ga, GEN_RST);
      bus_wr(ADDR_STAT, 16'h0007);
      @(posedge clk_sys);
      if (useCh4) ch4Evt <= 1'b1;
      else if (ch2) ch2Pin <= lvl;
      else boardLvl <= lvl;
      @(posedge clk_sys);
      ch4Evt <= 1'b0;
      repeat (3) @(posedge clk_sys);
      bus_rd(ga, v);
      check_val("captured value", hit ? cnt : GEN_RST, v);
      bus_rd(ADDR_STAT, v);
      check_val("capture status", {15'h0000, hit}, {15'h0000, v[ch2 ? STAT_CAP2_BIT : STAT_CAP3_BIT]});
   endtask : cap_step

   // rising edge, falling edge, then a channel-4 count event
   task cap_run(input logic ch2, input logic [FLD_W-1:0] code, input logic expR, input logic expF,
                input logic expC);
      bus_wr(ch2 ? ADDR_CH2_IOCTL : ADDR_IOCTL_HI, {12'h000, code});
      if (!ch2) chk_pin(1'b0, 1'b0);
      cap_step(ch2, 1'b0, 1'b1, 16'h0011, expR);
      cap_step(ch2, 1'b0, 1'b0, 16'h0022, expF);
      cap_step(ch2, 1'b1, 1'b0, 16'h0033, expC);
   endtask : cap_run

   task test_done;
      $display("checks %0d, mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : test_done

   // watchdog well beyond the expected run of about 820 cycles
   initial begin
      #1000000;
      fail_count++;
      test_done();
   end

   initial begin
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      // reset values, unmapped address included
      chk_pin(1'b0, 1'b0);
      for (int a = 0; a < 8; a++) begin
         bus_rd(a[ADDR_W-1:0], rdVal);
         check_val("reset read", 16'h0000, rdVal);
      end
      bus_wr(ADDR_IOCTL_HI, 16'h00A5);
      bus_rd(ADDR_IOCTL_HI, rdVal);
      check_val("io control readback", 16'h00A5, rdVal);
      bus_wr(3'h7, 16'hFFFF);
      bus_rd(3'h7, rdVal);
      check_val("unmapped read", 16'h0000, rdVal);
      // every output code: initial level, then one compare match
      for (int c = 0; c < 8; c++) begin
         act = c[1:0];
         bus_wr(ADDR_CTRL, 16'h0000);
         bus_wr(ADDR_GENA, 16'h0005);
         bus_wr(ADDR_CNT, 16'h0000);
         bus_wr(ADDR_STAT, 16'h0007);
         bus_wr(ADDR_IOCTL_HI, {12'h000, c[3:0]});
         chk_pin(act != ACT_NONE, (act != ACT_NONE) & c[2]);
         bus_wr(ADDR_CTRL, 16'h0001);
         repeat (12) @(posedge clk_sys);
         bus_wr(ADDR_CTRL, 16'h0000);
         chk_pin(act != ACT_NONE, (act == ACT_HIGH) | ((act == ACT_TOG) & ~c[2]));
         bus_rd(ADDR_STAT, rdVal);
         check_val("compare status", 16'h0001, rdVal);
      end
      // capture modes of channel 3 with the counter stopped
      cap_run(1'b0, 4'h8, 1'b1, 1'b0, 1'b0);
      cap_run(1'b0, 4'h9, 1'b0, 1'b1, 1'b0);
      cap_run(1'b0, 4'hA, 1'b1, 1'b1, 1'b0);
      cap_run(1'b0, 4'hB, 1'b1, 1'b1, 1'b0);
      cap_run(1'b0, 4'hC, 1'b0, 1'b0, 1'b1);
      cap_run(1'b0, 4'hF, 1'b0, 1'b0, 1'b1);
      // channel 2 capture edges on its own pin
      cap_run(1'b1, 4'h8, 1'b1, 1'b0, 1'b0);
      cap_run(1'b1, 4'h9, 1'b0, 1'b1, 1'b0);
      cap_run(1'b1, 4'hA, 1'b1, 1'b1, 1'b0);
      cap_run(1'b1, 4'hB, 1'b1, 1'b1, 1'b0);
      cap_run(1'b1, 4'hC, 1'b1, 1'b0, 1'b0);
      cap_run(1'b1, 4'hE, 1'b1, 1'b1, 1'b0);
      test_done();
   end
endmodule : tcio_ch3_io_ctrl_bench
